// ---- hw/pstr_pkg.sv ----
package pstr_pkg;
  // widths
  localparam int PC_W = 10;
  localparam int DA_W = 7;
  localparam int DATA_W = 8;
  localparam int WORD_W = 14;
  localparam int RAM_AW = 5;
  localparam int RAM_WORDS = 32;
  // instruction cycle phases
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // data memory map
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_MEM_PTR = 7'h01;
  localparam logic [6:0] ADDR_ACC = 7'h05;
  localparam logic [6:0] ADDR_PC_LOW = 7'h06;
  localparam logic [6:0] ADDR_TBL_PTR = 7'h07;
  localparam logic [6:0] ADDR_TBL_HIGH = 7'h08;
  localparam logic [6:0] ADDR_RAM_LO = 7'h20;
  localparam logic [6:0] ADDR_RAM_HI = 7'h3F;
  // reset and read-back values
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [6:0] MEM_PTR_RESET = 7'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] TBL_HIGH_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic MEM_PTR_TOP_READ = 1'h1;
  localparam logic [1:0] TBL_HIGH_PAD = 2'h0;
  localparam logic [1:0] LAST_PAGE = 2'h3;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [9:0] PC_STEP = 10'h001;
  // instruction fields
  localparam int OP_HI = 13;
  localparam int OP_LO = 10;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  // opcodes
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_JMP = 4'h1,
    OP_CALL = 4'h2,
    OP_RETURN = 4'h3,
    OP_TRDC = 4'h4,
    OP_TRDL = 4'h5,
    OP_LDI = 4'h6,
    OP_STA = 4'h7,
    OP_LDM = 4'h8,
    OP_SET = 4'h9,
    OP_CLR = 4'hA,
    OP_SKS = 4'hB,
    OP_SKC = 4'hC,
    OP_SIZ = 4'hD
  } pstr_op_t;
endpackage

// ---- hw/pstr_phase_gen.sv ----
`timescale 1ns/100ps
module pstr_phase_gen (
  input wire logic clk,
  input wire logic rst,
  output logic [1:0] phase,
  output logic cyc_end
);
  // four system clocks make one instruction cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= pstr_pkg::PHASE_FIRST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // one-clock enable on the last phase
  assign cyc_end = (phase == pstr_pkg::PHASE_LAST);
endmodule

// ---- hw/pstr_data_mem.sv ----
`timescale 1ns/100ps
module pstr_data_mem (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [pstr_pkg::RAM_WORDS];

  // general purpose bytes, written at cycle end
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// ---- hw/pstr_sequencer.sv ----
`timescale 1ns/100ps
module pstr_sequencer (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [13:0] PM_DATA,
  output logic [9:0] PM_ADDR,
  output logic [1:0] PHASE,
  output logic CYCLE_END,
  output logic [9:0] PROGRAM_COUNTER,
  output logic [7:0] ACCUMULATOR,
  output logic STACK_FULL
);
  logic [1:0] phase;
  logic cyc_end;
  logic [9:0] pc;
  logic [9:0] pm_addr;
  logic [13:0] ir;
  logic ir_valid;
  logic tbl_cycle;
  logic [6:0] tbl_dest;
  logic [9:0] stack;
  logic stack_index;
  logic [6:0] memory_pointer;
  logic [7:0] table_pointer;
  logic [5:0] table_high_byte;
  logic [7:0] acc;
  pstr_pkg::pstr_op_t op;
  logic exec;
  logic [6:0] src_addr;
  logic [6:0] eff_addr;
  logic null_ind;
  logic in_ram;
  logic [7:0] ram_rd;
  logic [7:0] rd_byte;
  logic [7:0] bit_mask;
  logic [7:0] inc_byte;
  logic do_wr;
  logic [7:0] wr_byte;
  logic do_jump;
  logic [9:0] jump_tgt;
  logic do_skip;
  logic do_push;
  logic do_pop;
  logic acc_ld;
  logic [7:0] acc_val;
  logic tbl_start;
  logic [9:0] tbl_addr;
  logic wr_eff;
  logic pcl_jump;
  logic flush;
  logic [9:0] next_pc;
  logic [9:0] next_pm_addr;
  logic ram_we;

  pstr_phase_gen u_phase (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .phase(phase),
    .cyc_end(cyc_end)
  );

  pstr_data_mem u_ram (
    .clk(REF_CLK),
    .wr_en(ram_we),
    .wr_addr(eff_addr[4:0]),
    .wr_data(wr_byte),
    .rd_addr(eff_addr[4:0]),
    .rd_data(ram_rd)
  );

  // decode of the word held in the execute stage
  assign op = pstr_pkg::pstr_op_t'(ir[pstr_pkg::OP_HI:pstr_pkg::OP_LO]);
  assign exec = ir_valid && !tbl_cycle;
  assign bit_mask = pstr_pkg::BIT_ONE << ir[pstr_pkg::BIT_HI:pstr_pkg::BIT_LO];

  // operand address, with 00H redirected through the pointer
  assign src_addr = tbl_cycle ? tbl_dest : ir[6:0];
  assign eff_addr = (src_addr == pstr_pkg::ADDR_INDIRECT) ?
                    memory_pointer : src_addr;
  assign null_ind = (src_addr == pstr_pkg::ADDR_INDIRECT) &&
                    (memory_pointer == pstr_pkg::ADDR_INDIRECT);
  assign in_ram = (eff_addr >= pstr_pkg::ADDR_RAM_LO) &&
                  (eff_addr <= pstr_pkg::ADDR_RAM_HI);

  // data memory read mux
  always_comb begin
    rd_byte = pstr_pkg::READ_ZERO;
    if (!null_ind) begin
      case (eff_addr)
        pstr_pkg::ADDR_MEM_PTR: begin
          rd_byte = {pstr_pkg::MEM_PTR_TOP_READ, memory_pointer};
        end
        pstr_pkg::ADDR_ACC: begin
          rd_byte = acc;
        end
        pstr_pkg::ADDR_PC_LOW: begin
          rd_byte = pc[7:0];
        end
        pstr_pkg::ADDR_TBL_PTR: begin
          rd_byte = table_pointer;
        end
        pstr_pkg::ADDR_TBL_HIGH: begin
          rd_byte = {pstr_pkg::TBL_HIGH_PAD, table_high_byte};
        end
        default: begin
          rd_byte = in_ram ? ram_rd : pstr_pkg::READ_ZERO;
        end
      endcase
    end
  end

  assign inc_byte = rd_byte + pstr_pkg::BYTE_ONE;

  // execute stage: one action per instruction cycle
  always_comb begin
    do_wr = 1'b0;
    wr_byte = rd_byte;
    do_jump = 1'b0;
    jump_tgt = ir[9:0];
    do_skip = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    acc_ld = 1'b0;
    acc_val = acc;
    tbl_start = 1'b0;
    if (tbl_cycle) begin
      do_wr = 1'b1;
      wr_byte = PM_DATA[7:0];
    end else if (exec) begin
      unique case (op)
        pstr_pkg::OP_JMP: begin
          do_jump = 1'b1;
        end
        pstr_pkg::OP_CALL: begin
          do_jump = 1'b1;
          do_push = 1'b1;
        end
        pstr_pkg::OP_RETURN: begin
          do_jump = 1'b1;
          do_pop = 1'b1;
          jump_tgt = stack;
        end
        pstr_pkg::OP_TRDC, pstr_pkg::OP_TRDL: begin
          tbl_start = 1'b1;
        end
        pstr_pkg::OP_LDI: begin
          acc_ld = 1'b1;
          acc_val = ir[7:0];
        end
        pstr_pkg::OP_STA: begin
          do_wr = 1'b1;
          wr_byte = acc;
        end
        pstr_pkg::OP_LDM: begin
          acc_ld = 1'b1;
          acc_val = rd_byte;
        end
        pstr_pkg::OP_SET: begin
          do_wr = 1'b1;
          wr_byte = rd_byte | bit_mask;
        end
        pstr_pkg::OP_CLR: begin
          do_wr = 1'b1;
          wr_byte = rd_byte & ~bit_mask;
        end
        pstr_pkg::OP_SKS: begin
          do_skip = |(rd_byte & bit_mask);
        end
        pstr_pkg::OP_SKC: begin
          do_skip = ~|(rd_byte & bit_mask);
        end
        pstr_pkg::OP_SIZ: begin
          do_wr = 1'b1;
          wr_byte = inc_byte;
          do_skip = (inc_byte == pstr_pkg::READ_ZERO);
        end
        default: begin
        end
      endcase
    end
  end

  // a write lands only where something is really mapped
  assign wr_eff = do_wr && !null_ind;
  assign pcl_jump = wr_eff && (eff_addr == pstr_pkg::ADDR_PC_LOW);
  // ram takes its byte only at cycle end and only inside its window
  assign ram_we = cyc_end && wr_eff && in_ram;

  // table address: current page or forced last page
  assign tbl_addr = (op == pstr_pkg::OP_TRDL) ?
                    {pstr_pkg::LAST_PAGE, table_pointer} :
                    {pc[9:8], table_pointer};

  // any transfer of control discards the prefetched word
  assign flush = pcl_jump || do_jump || do_skip;

  // next program counter
  always_comb begin
    if (pcl_jump) begin
      next_pc = {pc[9:8], wr_byte};
    end else if (do_jump) begin
      next_pc = jump_tgt;
    end else if (!tbl_cycle) begin
      next_pc = pc + pstr_pkg::PC_STEP;
    end else begin
      next_pc = pc;
    end
  end

  // table cycle borrows the program memory port for one cycle
  assign next_pm_addr = tbl_start ? tbl_addr : next_pc;

  // program counter and memory address
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pc <= pstr_pkg::PC_RESET;
      pm_addr <= pstr_pkg::PC_RESET;
    end else if (cyc_end) begin
      pc <= next_pc;
      pm_addr <= next_pm_addr;
    end
  end

  // fetch register and pipeline validity
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ir <= {pstr_pkg::WORD_W{1'b0}};
      ir_valid <= 1'b0;
    end else if (cyc_end) begin
      if (!tbl_cycle) begin
        ir <= PM_DATA;
      end
      ir_valid <= !flush;
    end
  end

  // table read second cycle
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tbl_cycle <= 1'b0;
      tbl_dest <= pstr_pkg::ADDR_INDIRECT;
    end else if (cyc_end) begin
      tbl_cycle <= tbl_start;
      if (tbl_start) begin
        tbl_dest <= ir[6:0];
      end
    end
  end

  // table high byte, loaded only by a table read
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      table_high_byte <= pstr_pkg::TBL_HIGH_RESET;
    end else if (cyc_end && tbl_cycle) begin
      table_high_byte <= PM_DATA[13:8];
    end
  end

  // software-visible pointers
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      memory_pointer <= pstr_pkg::MEM_PTR_RESET;
      table_pointer <= pstr_pkg::BYTE_RESET;
    end else if (cyc_end && wr_eff) begin
      if (eff_addr == pstr_pkg::ADDR_MEM_PTR) begin
        memory_pointer <= wr_byte[6:0];
      end
      if (eff_addr == pstr_pkg::ADDR_TBL_PTR) begin
        table_pointer <= wr_byte;
      end
    end
  end

  // accumulator, also mapped into data memory
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      acc <= pstr_pkg::BYTE_RESET;
    end else if (cyc_end) begin
      if (acc_ld) begin
        acc <= acc_val;
      end else if (wr_eff && eff_addr == pstr_pkg::ADDR_ACC) begin
        acc <= wr_byte;
      end
    end
  end

  // one-level return stack, hidden from data memory
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stack <= pstr_pkg::PC_RESET;
      stack_index <= 1'b0;
    end else if (cyc_end) begin
      if (do_push) begin
        stack <= pc;
        stack_index <= 1'b1;
      end else if (do_pop) begin
        stack_index <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PROGRAM_COUNTER <= pstr_pkg::PC_RESET;
      ACCUMULATOR <= pstr_pkg::BYTE_RESET;
      STACK_FULL <= 1'b0;
    end else begin
      PROGRAM_COUNTER <= pc;
      ACCUMULATOR <= acc;
      STACK_FULL <= stack_index;
    end
  end

  assign PM_ADDR = pm_addr;
  assign PHASE = phase;
  assign CYCLE_END = cyc_end;
endmodule

// ---- tb/pstr_sequencer_monitor.sv ----
`timescale 1ns/100ps
module pstr_sequencer_monitor (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [13:0] PM_DATA,
  input wire logic [9:0] PM_ADDR,
  input wire logic [1:0] PHASE,
  input wire logic CYCLE_END,
  input wire logic [9:0] PROGRAM_COUNTER,
  input wire logic [7:0] ACCUMULATOR,
  input wire logic STACK_FULL
);
  logic [13:0] ir;
  logic [9:0] stk;
  logic dead;
  logic tbl;
  logic live;
  logic last;
  logic [3:0] op;
  logic [9:0] tgt;
  logic [1:0] page;
  default clocking
    @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  // decode of the shadow word
  assign op = ir[13:10];
  assign tgt = ir[9:0];
  assign last = ir[10];
  assign page = PM_ADDR[9:8];
  assign live = !dead && !tbl;
  // word under execution; a table word is not an instruction
  always_ff @(posedge REF_CLK) begin
    if (CYCLE_END && !tbl) begin
      ir <= PM_DATA;
    end
  end
  // dead after a jump, call or return, tbl during the table access
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      dead <= 1'b1;
      tbl <= 1'b0;
    end else if (CYCLE_END) begin
      dead <= live && op inside {4'h1, 4'h2, 4'h3};
      tbl <= live && op inside {4'h4, 4'h5};
    end
  end
  // a call saves the address after it
  always_ff @(posedge REF_CLK) begin
    if (CYCLE_END && live && op == 4'h2) begin
      stk <= PM_ADDR;
    end
  end
  sequence boot_cycle;
    $fell(SYS_RST) ##3 CYCLE_END;
  endsequence
  sequence done(logic [3:0] code);
    CYCLE_END && live && op == code;
  endsequence
  chk_phase_step: assert property (
    PHASE != 2'h3 |=> PHASE == $past(PHASE) + 2'h1)
    else $error("phase did not step");
  chk_cycle_end: assert property (
    PHASE == 2'h3 |-> CYCLE_END ##1 !CYCLE_END [*3])
    else $error("cycle end misplaced");
  chk_addr_hold: assert property (
    !CYCLE_END |=> $stable(PM_ADDR))
    else $error("fetch address moved mid cycle");
  chk_reset_clear: assert property (
    disable iff (1'b0) $fell(SYS_RST) |-> PM_ADDR == 10'h000
    && PROGRAM_COUNTER == 10'h000 && !STACK_FULL)
    else $error("reset state wrong");
  chk_first_step: assert property (
    boot_cycle |=> PM_ADDR == 10'h001 ##1 PROGRAM_COUNTER == 10'h001)
    else $error("counter did not step by one");
  chk_stack_moves: assert property (
    $changed(STACK_FULL) |-> $past(CYCLE_END, 2))
    else $error("stack moved off cycle end");
  chk_jump_load: assert property (
    done(4'h1) |=> PM_ADDR == $past(tgt)
    ##4 PM_ADDR == $past(tgt, 5) + 10'h001)
    else $error("jump target or dummy cycle wrong");
  chk_call_push: assert property (
    done(4'h2) |=> PM_ADDR == $past(tgt) ##1 STACK_FULL)
    else $error("call target or push wrong");
  chk_ret_pop: assert property (
    done(4'h3) |=> PM_ADDR == stk ##1 !STACK_FULL)
    else $error("return address wrong");
  chk_table_page: assert property (
    CYCLE_END && live && op[3:1] == 3'h2 |=> $past(last)
    ? page == 2'h3 : page == $past(page))
    else $error("table page wrong");
endmodule
bind pstr_sequencer pstr_sequencer_monitor i_mon (
  .REF_CLK(REF_CLK),
  .SYS_RST(SYS_RST),
  .PM_DATA(PM_DATA),
  .PM_ADDR(PM_ADDR),
  .PHASE(PHASE),
  .CYCLE_END(CYCLE_END),
  .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .ACCUMULATOR(ACCUMULATOR),
  .STACK_FULL(STACK_FULL)
);

// ---- tb/test_program_sequencer_table_read.sv ----
`timescale 1ns/100ps
module test_program_sequencer_table_read;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [13:0] pm_data = 14'h0000;
  logic [9:0] pm_addr;
  logic [9:0] pc;
  logic [1:0] phase;
  logic cyc_end;
  logic [7:0] acc;
  logic stack_full;
  logic [13:0] rom [1024];
  int mismatches = 0;
  int tests_run = 0;
  // count a compare, report a mismatch
  `define CHK(a, b, m) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end
  pstr_sequencer i_dut (
    .REF_CLK(ref_clk),
    .SYS_RST(sys_rst),
    .PM_DATA(pm_data),
    .PM_ADDR(pm_addr),
    .PHASE(phase),
    .CYCLE_END(cyc_end),
    .PROGRAM_COUNTER(pc),
    .ACCUMULATOR(acc),
    .STACK_FULL(stack_full)
  );
  // 100 ns period
  always #50 ref_clk = ~ref_clk;
  // program memory, one clock of latency
  always @(posedge ref_clk) begin
    pm_data <= rom[pm_addr];
  end
  // verdict and stop
  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one program word
  task automatic put(input logic [9:0] a, input logic [3:0] op,
      input logic [9:0] f);
    rom[a] = {op, f};
  endtask
  // enter reset, blank the program
  task automatic fresh();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    foreach (rom[i]) begin
      rom[i] = 14'h0000;
    end
  endtask
  // four clocks of reset, then run
  task automatic go();
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask
  // run until the counter shows a, then n more clocks
  task automatic halt_at(input logic [9:0] a, input int n);
    int i;
    for (i = 0; i < 600 && pc !== a; i++) begin
      @(posedge ref_clk);
    end
    if (i == 600) begin
      mismatches++;
      $display("wrong value at %0t: counter never reached", $time);
      conclude();
    end else begin
      repeat (n) @(posedge ref_clk);
    end
  endtask
  // nested calls on a one-level stack
  task automatic s_calls();
    fresh();
    put(10'h000, 4'h2, 10'h100);
    put(10'h001, 4'h6, 10'h011);
    put(10'h100, 4'h2, 10'h300);
    put(10'h101, 4'h6, 10'h022);
    put(10'h102, 4'h3, 10'h000);
    put(10'h300, 4'h3, 10'h000);
    go();
    halt_at(10'h301, 0);
    `CHK(stack_full, 1'b1, "stack empty in call")
    halt_at(10'h103, 16);
    `CHK(acc, 8'h22, "older return kept")
    `CHK(stack_full, 1'b0, "stack kept after return")
  endtask
  // taken and untaken skips, bit set and clear
  task automatic s_skips();
    fresh();
    put(10'h000, 4'h6, 10'h0FF);
    put(10'h001, 4'hD, 10'h005);
    put(10'h002, 4'h9, 10'h305);
    put(10'h003, 4'h9, 10'h005);
    put(10'h004, 4'hB, 10'h005);
    put(10'h005, 4'h9, 10'h285);
    put(10'h006, 4'hB, 10'h085);
    put(10'h007, 4'h9, 10'h385);
    put(10'h008, 4'hA, 10'h005);
    put(10'h009, 4'hC, 10'h005);
    put(10'h00A, 4'h9, 10'h205);
    put(10'h00B, 4'h1, 10'h00B);
    go();
    halt_at(10'h00C, 16);
    `CHK(acc, 8'h80, "skip or bit op wrong")
  endtask
  // last and current page reads, read-only high byte
  task automatic s_table();
    fresh();
    rom[10'h334] = 14'h2A5C;
    rom[10'h02A] = 14'h3F81;
    put(10'h000, 4'h6, 10'h034);
    put(10'h001, 4'h7, 10'h007);
    put(10'h002, 4'h5, 10'h005);
    put(10'h003, 4'h6, 10'h0FF);
    put(10'h004, 4'h7, 10'h008);
    put(10'h005, 4'h8, 10'h008);
    put(10'h006, 4'h7, 10'h007);
    put(10'h007, 4'h4, 10'h005);
    put(10'h008, 4'h8, 10'h008);
    put(10'h009, 4'h1, 10'h009);
    go();
    halt_at(10'h00A, 16);
    `CHK(acc, 8'h3F, "table read wrong")
  endtask
  // reserved read, indirect access, short jump
  task automatic s_mem();
    fresh();
    put(10'h000, 4'h6, 10'h077);
    put(10'h001, 4'h8, 10'h010);
    put(10'h002, 4'h1, 10'h002);
    go();
    halt_at(10'h003, 16);
    `CHK(acc, 8'h00, "reserved not zero")
    fresh();
    put(10'h000, 4'h1, 10'h100);
    put(10'h100, 4'h6, 10'h03F);
    put(10'h101, 4'h7, 10'h001);
    put(10'h102, 4'h6, 10'h05A);
    put(10'h103, 4'h7, 10'h000);
    put(10'h104, 4'h6, 10'h000);
    put(10'h105, 4'h8, 10'h000);
    put(10'h106, 4'h7, 10'h006);
    put(10'h15A, 4'h1, 10'h15A);
    go();
    halt_at(10'h15B, 16);
    `CHK(acc, 8'h5A, "indirect data lost")
  endtask
  // main sequence
  initial begin
    s_calls();
    s_skips();
    s_table();
    s_mem();
    conclude();
  end
endmodule
